// >>> include/uart_amfc_defines.svh
// register offsets, field positions and reset values of the address-match and flow-control block
`ifndef UART_AMFC_DEFINES_SVH
`define UART_AMFC_DEFINES_SVH
`define OFS_CONTROL_TWO 4'h4
`define OFS_CONTROL_THREE 4'h8
`define OFS_EVENT_STATUS 4'hC
`define OFS_EVENT_MASK 4'h0
`define CTL_RESET 32'h00000000
`define BIT_ADDR_LEN 4
`define LSB_NODE_LOW 24
`define LSB_NODE_HIGH 28
`define BIT_ERR_IE 0
`define BIT_HALF_DUPLEX 3
`define BIT_DMA_RX 6
`define BIT_DMA_TX 7
`define BIT_RTS_EN 8
`define BIT_CTS_EN 9
`define CTL2_WMASK 32'hFF000010
`define CTL3_WMASK 32'h000003C9
`define EVT_CHAR_MATCH 0
`define EVT_ADDR_WAKE 1
`define EVT_ERROR 2
`define EVT_CTS_HOLD 3
`define EVT_WIDTH 4
`endif

// >>> include/uart_amfc_pkg.sv
// types for the address-match and flow-control block
package uart_amfc_pkg;
  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_WAIT = 2'b01,
    TX_SEND = 2'b11
  } tx_state_t;
endpackage

// >>> include/addr_cmp_if.sv
// carrier between the top module and the address comparator
`timescale 1ns/1ns
interface addr_cmp_if;
  logic [7:0] rx_byte;
  logic [3:0] node_low;
  logic [3:0] node_high;
  logic addr_len_7;
  logic char_hit;
  logic addr_hit;
  modport top (output rx_byte, output node_low, output node_high, output addr_len_7,
    input char_hit, input addr_hit);
  modport cmp (input rx_byte, input node_low, input node_high, input addr_len_7,
    output char_hit, output addr_hit);
endinterface

// >>> design/addr_compare.sv
// combinational node-address and character comparator
`timescale 1ns/1ns
module addr_compare
(
  addr_cmp_if.cmp c
);
  // address mark: msb set, node address in the low four bits, or the low seven with address length set
  always_comb
  begin
    c.char_hit = (c.rx_byte == {c.node_high, c.node_low});
    if (c.addr_len_7)
    begin
      c.addr_hit = c.rx_byte[7] &&
        (c.rx_byte[6:0] == {c.node_high[2:0], c.node_low});
    end
    else
    begin
      c.addr_hit = c.rx_byte[7] && (c.rx_byte[3:0] == c.node_low);
    end
  end
endmodule

// >>> design/uart_addr_match_flow_control.sv
// address match, error interrupt, dma request and rts/cts flow control logic
//
// Contract
// - compare received address marks with the low node address for wake-up
// - without mute, a byte equal to the node address sets character match
// - error interrupt enable gates framing, overrun and noise errors to interrupt
// - half-duplex bit selects half-duplex; change only while disabled
// - with rts enabled, ready output low only while receive buffer has room
// - with cts enabled, a character starts only while cts input is low
// - cts rising mid-character finishes it; pending data waits for cts low
// - address length chooses 4-bit low-field or 7-bit node comparison
`timescale 1ns/1ns
`include "uart_amfc_defines.svh"
module uart_addr_match_flow_control
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic uart_enable,
  input wire logic rx_enable,
  input wire logic mute_active,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic framing_error_flag,
  input wire logic overrun_error_flag,
  input wire logic noise_error_flag,
  input wire logic rx_buffer_free,
  input wire logic rx_buffer_full,
  input wire logic tx_data_pending,
  input wire logic tx_char_done,
  input wire logic cts_n,
  output logic tx_start,
  output logic rts_n,
  output logic half_duplex_enable,
  output logic character_match_flag,
  output logic addr_wake,
  output logic dma_rx_req,
  output logic dma_tx_req,
  output logic irq
);
  logic [31:0] ctl2_r, ctl2_nxt;
  logic [31:0] ctl3_r, ctl3_nxt;
  logic [`EVT_WIDTH-1:0] evt_r, evt_nxt;
  logic [`EVT_WIDTH-1:0] mask_r, mask_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic cts_s1_r, cts_s2_r;
  uart_amfc_pkg::tx_state_t tx_r, tx_nxt;
  logic tx_start_r, tx_start_nxt;
  logic rts_r, rts_nxt;
  logic cm_r, cm_nxt;
  logic wake_r, wake_nxt;
  logic drx_r, drx_nxt;
  logic dtx_r, dtx_nxt;
  logic irq_r, irq_nxt;
  logic err_prev_r, err_prev_nxt;
  logic [`EVT_WIDTH-1:0] evt_set;
  logic err_now;
  logic cts_ok;
  addr_cmp_if cmp_c ();

  addr_compare u_cmp
  (
    .c(cmp_c)
  );

  function automatic logic [31:0] reg_sel(input logic [3:0] a, input logic [31:0] c2,
    input logic [31:0] c3, input logic [`EVT_WIDTH-1:0] ev, input logic [`EVT_WIDTH-1:0] mk);
    case (a)
      `OFS_CONTROL_TWO: reg_sel = c2;
      `OFS_CONTROL_THREE: reg_sel = c3;
      `OFS_EVENT_STATUS: reg_sel = {28'h0000000, ev};
      `OFS_EVENT_MASK: reg_sel = {28'h0000000, mk};
      default: reg_sel = 32'h00000000;
    endcase
  endfunction

  assign cmp_c.rx_byte = rx_data;
  assign cmp_c.node_low = ctl2_r[`LSB_NODE_LOW +: 4];
  assign cmp_c.node_high = ctl2_r[`LSB_NODE_HIGH +: 4];
  assign cmp_c.addr_len_7 = ctl2_r[`BIT_ADDR_LEN];

  // cts is a pin: two flops before use
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cts_s1_r <= 1'b1;
      cts_s2_r <= 1'b1;
    end
    else
    begin
      cts_s1_r <= cts_n;
      cts_s2_r <= cts_s1_r;
    end
  end

  assign err_now = framing_error_flag | overrun_error_flag | noise_error_flag;
  assign cts_ok = !ctl3_r[`BIT_CTS_EN] || !cts_s2_r;

  // register file
  always_comb
  begin
    ctl2_nxt = ctl2_r;
    ctl3_nxt = ctl3_r;
    mask_nxt = mask_r;
    rdata_nxt = 32'h00000000;
    if (reg_wr)
    begin
      // node address writes only land while receiver off or block disabled
      if (reg_addr == `OFS_CONTROL_TWO)
      begin
        ctl2_nxt[`BIT_ADDR_LEN] = uart_enable ? ctl2_r[`BIT_ADDR_LEN]
          : reg_wdata[`BIT_ADDR_LEN];
        if (!rx_enable || !uart_enable)
        begin
          ctl2_nxt[31:24] = reg_wdata[31:24];
        end
      end
      if (reg_addr == `OFS_CONTROL_THREE)
      begin
        ctl3_nxt = (ctl3_r & ~`CTL3_WMASK) | (reg_wdata & `CTL3_WMASK);
        if (uart_enable)
        begin
          ctl3_nxt[`BIT_HALF_DUPLEX] = ctl3_r[`BIT_HALF_DUPLEX];
          ctl3_nxt[`BIT_RTS_EN] = ctl3_r[`BIT_RTS_EN];
          ctl3_nxt[`BIT_CTS_EN] = ctl3_r[`BIT_CTS_EN];
        end
      end
      if (reg_addr == `OFS_EVENT_MASK)
      begin
        mask_nxt = reg_wdata[`EVT_WIDTH-1:0];
      end
    end
    if (reg_rd)
    begin
      rdata_nxt = reg_sel(reg_addr, ctl2_r, ctl3_r, evt_r, mask_r);
    end
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctl2_r <= `CTL_RESET;
      ctl3_r <= `CTL_RESET;
      mask_r <= '0;
      rdata_r <= 32'h00000000;
    end
    else
    begin
      ctl2_r <= ctl2_nxt;
      ctl3_r <= ctl3_nxt;
      mask_r <= mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // events, flags, interrupt
  always_comb
  begin
    evt_set = '0;
    cm_nxt = 1'b0;
    wake_nxt = 1'b0;
    evt_set[`EVT_CHAR_MATCH] = rx_valid && !mute_active && cmp_c.char_hit;
    evt_set[`EVT_ADDR_WAKE] = rx_valid && mute_active && cmp_c.addr_hit;
    evt_set[`EVT_ERROR] = err_now && !err_prev_r;
    evt_set[`EVT_CTS_HOLD] = (tx_r == uart_amfc_pkg::TX_WAIT) && !cts_ok;
    cm_nxt = evt_set[`EVT_CHAR_MATCH];
    wake_nxt = evt_set[`EVT_ADDR_WAKE];
    err_prev_nxt = err_now;
    evt_nxt = evt_r;
    if (reg_wr && reg_addr == `OFS_EVENT_STATUS)
    begin
      evt_nxt = evt_r & ~reg_wdata[`EVT_WIDTH-1:0];
    end
    // set beats a same-cycle clear
    evt_nxt = evt_nxt | evt_set;
    irq_nxt = |(evt_nxt & mask_nxt) ||
      (ctl3_nxt[`BIT_ERR_IE] && err_now);
    drx_nxt = ctl3_nxt[`BIT_DMA_RX] && rx_valid;
    dtx_nxt = ctl3_nxt[`BIT_DMA_TX] && tx_char_done;
    rts_nxt = ctl3_r[`BIT_RTS_EN] ? !(rx_buffer_free && !rx_buffer_full) : 1'b0;
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      evt_r <= '0;
      cm_r <= 1'b0;
      wake_r <= 1'b0;
      err_prev_r <= 1'b0;
      irq_r <= 1'b0;
      drx_r <= 1'b0;
      dtx_r <= 1'b0;
      rts_r <= 1'b0;
    end
    else
    begin
      evt_r <= evt_nxt;
      cm_r <= cm_nxt;
      wake_r <= wake_nxt;
      err_prev_r <= err_prev_nxt;
      irq_r <= irq_nxt;
      drx_r <= drx_nxt;
      dtx_r <= dtx_nxt;
      rts_r <= rts_nxt;
    end
  end

  // transmit gate: a character in flight completes whatever cts does; disabling the block drops back to idle
  always_comb
  begin
    tx_nxt = tx_r;
    tx_start_nxt = 1'b0;
    case (tx_r)
      uart_amfc_pkg::TX_IDLE:
      begin
        if (tx_data_pending && uart_enable)
        begin
          tx_nxt = uart_amfc_pkg::TX_WAIT;
        end
      end
      uart_amfc_pkg::TX_WAIT:
      begin
        if (!uart_enable)
        begin
          tx_nxt = uart_amfc_pkg::TX_IDLE;
        end
        else if (cts_ok)
        begin
          tx_start_nxt = 1'b1;
          tx_nxt = uart_amfc_pkg::TX_SEND;
        end
      end
      uart_amfc_pkg::TX_SEND:
      begin
        if (tx_char_done || !uart_enable)
        begin
          tx_nxt = uart_amfc_pkg::TX_IDLE;
        end
      end
      default: tx_nxt = uart_amfc_pkg::TX_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_r <= uart_amfc_pkg::TX_IDLE;
      tx_start_r <= 1'b0;
    end
    else
    begin
      tx_r <= tx_nxt;
      tx_start_r <= tx_start_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign tx_start = tx_start_r;
  assign rts_n = rts_r;
  assign half_duplex_enable = ctl3_r[`BIT_HALF_DUPLEX];
  assign character_match_flag = cm_r;
  assign addr_wake = wake_r;
  assign dma_rx_req = drx_r;
  assign dma_tx_req = dtx_r;
  assign irq = irq_r;
endmodule

// >>> tb/amfc_monitor.sv
// port checker of the address-match and flow-control block
`timescale 1ns/1ns
module amfc_monitor
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic uart_enable,
  input wire logic mute_active,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_buffer_free,
  input wire logic rx_buffer_full,
  input wire logic tx_char_done,
  input wire logic tx_start,
  input wire logic rts_n,
  input wire logic half_duplex_enable,
  input wire logic character_match_flag,
  input wire logic addr_wake,
  input wire logic dma_rx_req,
  input wire logic dma_tx_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence start_s;
    tx_start;
  endsequence
  sequence no_restart_s;
    !tx_start;
  endsequence
  AST_CHAR_CAUSE: assert property (character_match_flag |-> $past(rx_valid && !mute_active))
    else $error("char match without unmuted byte");
  AST_WAKE_CAUSE: assert property (addr_wake |-> $past(rx_valid && mute_active && rx_data[7]))
    else $error("wake without muted address mark");
  AST_WAKE_EXCL: assert property (!(addr_wake && character_match_flag))
    else $error("wake and char match together");
  AST_RTS_ROOM: assert property (rts_n |-> $past(!rx_buffer_free || rx_buffer_full))
    else $error("rts high while buffer has room");
  AST_ONE_START: assert property (start_s |=> no_restart_s)
    else $error("start pulse longer than one cycle");
  AST_DMA_RX: assert property (dma_rx_req |-> $past(rx_valid))
    else $error("rx dma request without byte");
  AST_DMA_TX: assert property (dma_tx_req |-> $past(tx_char_done))
    else $error("tx dma request without sent char");
  AST_HALF_HOLD: assert property (uart_enable && $past(uart_enable) |-> $stable(half_duplex_enable))
    else $error("half duplex changed while enabled");
  AST_RDATA: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
    else $error("read data outside answer cycle");
endmodule
bind uart_addr_match_flow_control amfc_monitor mon (.mclk, .rst_n, .reg_rd, .reg_rdata,
  .uart_enable, .mute_active, .rx_valid, .rx_data, .rx_buffer_free, .rx_buffer_full,
  .tx_char_done, .tx_start, .rts_n, .half_duplex_enable, .character_match_flag,
  .addr_wake, .dma_rx_req, .dma_tx_req);

// >>> tb/remote_model.sv
// remote serial partner: clear-to-send and character timing
`timescale 1ns/1ns
module remote_model
(
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic busy,
  input wire logic tx_start,
  output logic cts_n,
  output logic tx_char_done
);
  logic [2:0] cnt_r;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_r <= 3'h0;
      cts_n <= 1'h1;
      tx_char_done <= 1'h0;
    end
    else
    begin
      cts_n <= busy;
      tx_char_done <= cnt_r == 3'h1;
      // short character keeps the run brief
      if (tx_start)
        cnt_r <= 3'h4;
      else if (cnt_r != 3'h0)
        cnt_r <= cnt_r - 3'h1;
    end
  end
endmodule

// >>> tb/testbench.sv
// self-checking bench of the address-match and flow-control block
`timescale 1ns/1ns
`include "uart_amfc_defines.svh"
module testbench;
  logic mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, uart_enable = 0, rx_enable = 0;
  logic mute_active = 0, rx_valid = 0, framing_error_flag = 0, overrun_error_flag = 0;
  logic noise_error_flag = 0, rx_buffer_free = 1, rx_buffer_full = 0, tx_data_pending = 0;
  logic busy = 1, dx = 1, cts_n, tx_char_done, tx_start, rts_n, half_duplex_enable, irq;
  logic character_match_flag, addr_wake, dma_rx_req, dma_tx_req;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] rx_data = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata;
  int fails = 0, tests_run = 0, starts = 0, dones = 0, cyc = 0;
  uart_addr_match_flow_control uut (.mclk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .uart_enable, .rx_enable, .mute_active, .rx_valid, .rx_data,
    .framing_error_flag, .overrun_error_flag, .noise_error_flag, .rx_buffer_free,
    .rx_buffer_full, .tx_data_pending, .tx_char_done, .cts_n, .tx_start, .rts_n,
    .half_duplex_enable, .character_match_flag, .addr_wake, .dma_rx_req, .dma_tx_req, .irq);
  remote_model far (.mclk, .rst_n, .busy, .tx_start, .cts_n, .tx_char_done);
  initial
    forever #20 mclk = ~mclk;
  task finish_test;
    if (fails == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cyc++;
    if (tx_start === 1'b1)
      starts++;
    if (dma_tx_req === 1'b1)
      dones++;
    if (cyc == 3000)
    begin
      fails++;
      finish_test;
    end
  end
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    tests_run++;
    if (s !== e)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr <= 1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    reg_rd <= 1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 0;
    #1;
    chk("rdata", e, reg_rdata);
  endtask
  // one received byte; flags stand only in the cycle after it
  task rx(input logic [7:0] b, input logic m, input logic ec, input logic ew);
    @(posedge mclk);
    rx_valid <= 1;
    rx_data <= b;
    mute_active <= m;
    @(posedge mclk);
    rx_valid <= 0;
    #1;
    chk("match", ec, character_match_flag);
    chk("wake", ew, addr_wake);
    chk("dma_rx", dx, dma_rx_req);
  endtask
  initial
  begin
    repeat (10) @(posedge mclk);
    rst_n <= 1;
    rd(`OFS_CONTROL_TWO, `CTL_RESET);
    rd(`OFS_CONTROL_THREE, `CTL_RESET);
    wr(`OFS_CONTROL_TWO, 32'hA5FFFFFF);
    wr(`OFS_CONTROL_THREE, 32'hFFFFFFFF);
    wr(4'h1, 32'hFFFFFFFF);
    rd(`OFS_CONTROL_TWO, 32'hA5000010);
    rd(`OFS_CONTROL_THREE, 32'h000003C9);
    rd(4'h1, 32'h0);
    chk("half", 1, half_duplex_enable);
    @(posedge mclk);
    uart_enable <= 1;
    rx_enable <= 1;
    wr(`OFS_CONTROL_TWO, 32'h0);
    wr(`OFS_CONTROL_THREE, 32'h0);
    rd(`OFS_CONTROL_TWO, 32'hA5000010);
    rd(`OFS_CONTROL_THREE, 32'h00000308);
    wr(`OFS_CONTROL_THREE, 32'h000000C1);
    rx(8'hA5, 0, 1, 0);
    rx(8'h5A, 0, 0, 0);
    rx(8'hA5, 1, 0, 1);
    rx(8'h25, 1, 0, 0);
    rx(8'hD5, 1, 0, 0);
    rd(`OFS_EVENT_STATUS, 32'h3);
    wr(`OFS_EVENT_MASK, 32'h1);
    tick(1);
    chk("irq", 1, irq);
    wr(`OFS_EVENT_STATUS, 32'h1);
    tick(1);
    chk("irq", 0, irq);
    rd(`OFS_EVENT_STATUS, 32'h2);
    for (int i = 0; i < 4; i++)
    begin
      // last pass with the error enable off
      if (i == 3)
        wr(`OFS_CONTROL_THREE, 32'h000000C0);
      @(posedge mclk);
      {noise_error_flag, overrun_error_flag, framing_error_flag} <= 3'h1 << (i % 3);
      tick(2);
      chk("irq", i < 3, irq);
      @(posedge mclk);
      {noise_error_flag, overrun_error_flag, framing_error_flag} <= 3'h0;
    end
    chk("rts", 0, rts_n);
    @(posedge mclk);
    rx_buffer_full <= 1;
    tick(2);
    chk("rts", 1, rts_n);
    @(posedge mclk);
    rx_buffer_full <= 0;
    rx_buffer_free <= 0;
    tick(2);
    chk("rts", 1, rts_n);
    @(posedge mclk);
    rx_buffer_free <= 1;
    tx_data_pending <= 1;
    tick(10);
    chk("starts", 0, starts);
    @(posedge mclk);
    busy <= 0;
    for (int k = 0; k < 20 && starts == 0; k++)
      tick(1);
    @(posedge mclk);
    busy <= 1;
    for (int k = 0; k < 20 && dones == 0; k++)
      tick(1);
    @(posedge mclk);
    tx_data_pending <= 0;
    tick(10);
    chk("starts", 1, starts);
    chk("dones", 1, dones);
    @(posedge mclk);
    uart_enable <= 0;
    dx = 0;
    wr(`OFS_CONTROL_TWO, 32'hA5000000);
    wr(`OFS_CONTROL_THREE, 32'h0);
    rx(8'hD5, 1, 0, 1);
    chk("half", 0, half_duplex_enable);
    finish_test;
  end
endmodule
